// [core/ucs_bit_timer.sv]
// Bit-period tick generator for one serial channel.
`timescale 1ns/10ps
`default_nettype none
module ucs_bit_timer (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Control.
	input wire logic run,
	input wire logic restart,
	input wire logic half,
	input wire logic [ucs_pkg::DIV_W-1:0] divisor,
	// Bit tick.
	output logic tick
);
	import ucs_pkg::*;

	logic [DIV_W-1:0] cnt_r;
	logic [DIV_W-1:0] cnt_nxt;
	wire [DIV_W-1:0] load_w = half ? (divisor >> 1) : divisor;
	wire zero_w = (cnt_r == '0);

	assign tick = run & zero_w & ~restart;
	assign cnt_nxt = restart ? load_w :
		(!run) ? cnt_r :
		zero_w ? divisor : cnt_r - 1'b1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule
`default_nettype wire

// [core/ucs_channel_unit.sv]
// Two-channel serial unit: start/stop triggers, transmit and receive channel.
// Functional notes
// - Start trigger one sets channel run status, entering communication wait.
// - Stop trigger one clears channel run status and halts its operation.
// - Stopped channel keeps control, shift register, pin levels and errors.
// - Transmit status bit 5 reads one while the buffer holds data.
// - Zero bits written to start or stop triggers do nothing.
//
// The register addresses and register access over Avalon-MM were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ucs_channel_unit (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Avalon-MM slave.
	input wire ucs_pkg::ucs_av_req_s av_req,
	output ucs_pkg::ucs_av_rsp_s av_rsp,
	// Serial pins.
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic serial_clock_pin,
	// Interrupt.
	output logic irq
);
	import ucs_pkg::*;

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction

	// Bus handshake: one wait cycle, then the request is accepted.
	logic ack_r;
	logic [DATA_W-1:0] rdata_r;
	logic [DATA_W-1:0] rdata_nxt;
	wire req_w = av_req.read | av_req.write;
	wire accept_w = req_w & ack_r;
	wire wr_w = av_req.write & accept_w;
	wire rd_w = av_req.read & accept_w;
	wire [ADDR_W-1:0] adr_w = av_req.address;
	wire [DATA_W-1:0] wd_w = av_req.writedata;
	assign av_rsp.waitrequest = req_w & ~ack_r;
	assign av_rsp.readdata = rdata_r;

	// Registers.
	logic [NUM_CH-1:0] run_r;
	logic [DIV_W-1:0] div_r;
	logic [2:0] ctl_r;
	logic [IRQ_W-1:0] irq_st_r;
	logic [IRQ_W-1:0] irq_en_r;
	logic [BYTE_W-1:0] tx_buf_r;
	logic tx_bff_r;
	logic [BYTE_W-1:0] rx_data_r;
	logic rx_valid_r;
	logic fe_r;
	logic pe_r;
	logic ov_r;

	wire [NUM_CH-1:0] start_w = (wr_w && hit(adr_w, OFF_START)) ?
		wd_w[NUM_CH-1:0] : '0;
	wire [NUM_CH-1:0] stop_w = (wr_w && hit(adr_w, OFF_STOP)) ?
		wd_w[NUM_CH-1:0] : '0;
	wire [NUM_CH-1:0] run_nxt = (run_r | start_w) & ~stop_w;
	wire tx_wr_w = wr_w & hit(adr_w, OFF_TX_DATA);
	wire err_clr_w = wr_w & hit(adr_w, OFF_ERR_CLEAR);
	wire irq_clr_w = wr_w & hit(adr_w, OFF_IRQ_CLEAR);
	wire rx_rd_w = rd_w & hit(adr_w, OFF_RX_DATA);
	wire rxe_w = ctl_r[CTL_RXE_BIT];
	wire [1:0] par_w = ctl_r[CTL_PAR_MSB:CTL_PAR_LSB];

	// Input synchroniser and edge history.
	logic rx_meta_r;
	logic rx_s_r;
	logic rx_d_r;
	wire rx_fall_w = rx_d_r & ~rx_s_r;

	// Bit timers, one per channel.
	logic [NUM_CH-1:0] tick_w;
	logic [NUM_CH-1:0] tmr_run_w;
	logic [NUM_CH-1:0] tmr_restart_w;
	logic tx_go_w;
	logic rx_go_w;
	assign tmr_run_w[CH_TX] = run_r[CH_TX];
	assign tmr_run_w[CH_RX] = run_r[CH_RX] & rxe_w;
	assign tmr_restart_w[CH_TX] = tx_go_w;
	assign tmr_restart_w[CH_RX] = rx_go_w;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : g_tmr
			ucs_bit_timer u_tmr (
				.clk(clk),
				.rst(rst),
				.run(tmr_run_w[gi]),
				.restart(tmr_restart_w[gi]),
				.half(gi == CH_RX),
				.divisor(div_r),
				.tick(tick_w[gi])
			);
		end
	endgenerate

	// Transmit framer; holds every state while its channel is stopped.
	ucs_frame_e tx_st_r;
	ucs_frame_e tx_st_nxt;
	logic [BYTE_W-1:0] tx_sh_r;
	logic [BYTE_W-1:0] tx_sh_nxt;
	logic [2:0] tx_cnt_r;
	logic [2:0] tx_cnt_nxt;
	logic tx_par_r;
	logic tx_par_nxt;
	logic sout_r;
	logic sout_nxt;
	logic tx_end_w;
	wire tx_tick_w = tick_w[CH_TX];
	wire tx_pbit_w = (par_w == PAR_ODD) ? ~(^tx_buf_r) :
		(par_w == PAR_EVEN) ? ^tx_buf_r : 1'b0;

	always_comb begin
		tx_st_nxt = tx_st_r;
		tx_sh_nxt = tx_sh_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_par_nxt = tx_par_r;
		sout_nxt = sout_r;
		tx_go_w = 1'b0;
		tx_end_w = 1'b0;
		if (run_r[CH_TX]) begin
			case (tx_st_r)
				FR_IDLE: begin
					if (tx_bff_r) begin
						tx_go_w = 1'b1;
						tx_sh_nxt = tx_buf_r;
						tx_par_nxt = tx_pbit_w;
						sout_nxt = 1'b0;
						tx_st_nxt = FR_START;
					end
				end
				FR_START: begin
					if (tx_tick_w) begin
						sout_nxt = tx_sh_r[0];
						tx_sh_nxt = tx_sh_r >> 1;
						tx_cnt_nxt = '0;
						tx_st_nxt = FR_DATA;
					end
				end
				FR_DATA: begin
					if (tx_tick_w) begin
						if (tx_cnt_r == LAST_BIT) begin
							if (par_w == PAR_NONE) begin
								sout_nxt = 1'b1;
								tx_st_nxt = FR_STOP;
							end else begin
								sout_nxt = tx_par_r;
								tx_st_nxt = FR_PAR;
							end
						end else begin
							sout_nxt = tx_sh_r[0];
							tx_sh_nxt = tx_sh_r >> 1;
							tx_cnt_nxt = tx_cnt_r + 1'b1;
						end
					end
				end
				FR_PAR: begin
					if (tx_tick_w) begin
						sout_nxt = 1'b1;
						tx_st_nxt = FR_STOP;
					end
				end
				FR_STOP: begin
					if (tx_tick_w) begin
						tx_end_w = 1'b1;
						tx_st_nxt = FR_IDLE;
					end
				end
				default: begin
					tx_st_nxt = FR_IDLE;
				end
			endcase
		end
	end

	// Receive framer; advances only while running with receive enabled.
	ucs_frame_e rx_st_r;
	ucs_frame_e rx_st_nxt;
	logic [BYTE_W-1:0] rx_sh_r;
	logic [BYTE_W-1:0] rx_sh_nxt;
	logic [2:0] rx_cnt_r;
	logic [2:0] rx_cnt_nxt;
	logic rx_pbad_r;
	logic rx_pbad_nxt;
	logic rx_done_w;
	logic fe_set_w;
	wire rx_tick_w = tick_w[CH_RX];
	wire rx_par_w = (par_w == PAR_ODD) ? ~(^rx_sh_r) : ^rx_sh_r;
	wire pe_set_w = rx_done_w & rx_pbad_r & par_w[1];
	wire ov_set_w = rx_done_w & rx_valid_r & ~rx_rd_w;

	always_comb begin
		rx_st_nxt = rx_st_r;
		rx_sh_nxt = rx_sh_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_pbad_nxt = rx_pbad_r;
		rx_go_w = 1'b0;
		rx_done_w = 1'b0;
		fe_set_w = 1'b0;
		if (tmr_run_w[CH_RX]) begin
			case (rx_st_r)
				FR_IDLE: begin
					if (rx_fall_w) begin
						rx_go_w = 1'b1;
						rx_st_nxt = FR_START;
					end
				end
				FR_START: begin
					if (rx_tick_w) begin
						rx_cnt_nxt = '0;
						rx_pbad_nxt = 1'b0;
						rx_st_nxt = rx_s_r ? FR_IDLE : FR_DATA;
					end
				end
				FR_DATA: begin
					if (rx_tick_w) begin
						rx_sh_nxt = {rx_s_r, rx_sh_r[BYTE_W-1:1]};
						rx_cnt_nxt = rx_cnt_r + 1'b1;
						if (rx_cnt_r == LAST_BIT) begin
							rx_st_nxt = (par_w == PAR_NONE) ? FR_STOP : FR_PAR;
						end
					end
				end
				FR_PAR: begin
					if (rx_tick_w) begin
						rx_pbad_nxt = (rx_par_w != rx_s_r);
						rx_st_nxt = FR_STOP;
					end
				end
				FR_STOP: begin
					if (rx_tick_w) begin
						rx_done_w = 1'b1;
						fe_set_w = ~rx_s_r;
						rx_st_nxt = FR_IDLE;
					end
				end
				default: begin
					rx_st_nxt = FR_IDLE;
				end
			endcase
		end
	end

	// Register read mux.
	wire [IRQ_W-1:0] irq_ev_w = {fe_set_w | pe_set_w | ov_set_w,
		rx_done_w, tx_end_w};
	wire tx_busy_w = (tx_st_r != FR_IDLE);
	wire [BYTE_W-1:0] tx_stat_w = (BYTE_W'(tx_busy_w) << ST_BUSY_BIT) |
		(BYTE_W'(tx_bff_r) << ST_BUF_BIT);
	wire rx_busy_w = (rx_st_r != FR_IDLE);
	wire [BYTE_W-1:0] rx_stat_w = (BYTE_W'(rx_busy_w) << ST_BUSY_BIT) |
		(BYTE_W'(rx_valid_r) << ST_BUF_BIT) |
		(BYTE_W'(fe_r) << ST_FE_BIT) | (BYTE_W'(pe_r) << ST_PE_BIT) |
		(BYTE_W'(ov_r) << ST_OV_BIT);

	always_comb begin
		rdata_nxt = '0;
		case (adr_w)
			OFF_RUN: rdata_nxt = DATA_W'(run_r);
			OFF_TX_STATUS: rdata_nxt = DATA_W'(tx_stat_w);
			OFF_RX_STATUS: rdata_nxt = DATA_W'(rx_stat_w);
			OFF_RX_DATA: rdata_nxt = DATA_W'(rx_data_r);
			OFF_CONTROL: rdata_nxt = DATA_W'(ctl_r);
			OFF_DIVISOR: rdata_nxt = DATA_W'(div_r);
			OFF_IRQ_STATUS: rdata_nxt = DATA_W'(irq_st_r);
			OFF_IRQ_ENABLE: rdata_nxt = DATA_W'(irq_en_r);
			default: rdata_nxt = '0;
		endcase
	end

	assign irq = |(irq_st_r & irq_en_r);
	assign serial_out_pin = sout_r;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_r <= 1'b0;
			rdata_r <= '0;
			run_r <= '0;
			div_r <= DIV_RESET;
			ctl_r <= CTL_RESET;
			irq_en_r <= '0;
		end else begin
			ack_r <= req_w & ~ack_r;
			rdata_r <= (av_req.read & ~ack_r) ? rdata_nxt : rdata_r;
			run_r <= run_nxt;
			if (wr_w && hit(adr_w, OFF_DIVISOR)) begin
				div_r <= wd_w[DIV_W-1:0];
			end
			if (wr_w && hit(adr_w, OFF_CONTROL)) begin
				ctl_r <= wd_w[2:0];
			end
			if (wr_w && hit(adr_w, OFF_IRQ_ENABLE)) begin
				irq_en_r <= wd_w[IRQ_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_st_r <= '0;
			fe_r <= 1'b0;
			pe_r <= 1'b0;
			ov_r <= 1'b0;
			tx_buf_r <= '0;
			tx_bff_r <= 1'b0;
			rx_data_r <= '0;
			rx_valid_r <= 1'b0;
		end else begin
			irq_st_r <= irq_ev_w |
				(irq_st_r & ~(irq_clr_w ? wd_w[IRQ_W-1:0] : '0));
			fe_r <= fe_set_w | (fe_r & ~(err_clr_w & wd_w[ST_FE_BIT]));
			pe_r <= pe_set_w | (pe_r & ~(err_clr_w & wd_w[ST_PE_BIT]));
			ov_r <= ov_set_w | (ov_r & ~(err_clr_w & wd_w[ST_OV_BIT]));
			tx_buf_r <= tx_wr_w ? wd_w[BYTE_W-1:0] : tx_buf_r;
			tx_bff_r <= tx_wr_w | (tx_bff_r & ~tx_go_w);
			rx_data_r <= rx_done_w ? rx_sh_r : rx_data_r;
			rx_valid_r <= rx_done_w | (rx_valid_r & ~rx_rd_w);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_st_r <= FR_IDLE;
			tx_sh_r <= '0;
			tx_cnt_r <= '0;
			tx_par_r <= 1'b0;
			sout_r <= 1'b1;
			serial_clock_pin <= 1'b1;
		end else begin
			tx_st_r <= tx_st_nxt;
			tx_sh_r <= tx_sh_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_par_r <= tx_par_nxt;
			sout_r <= sout_nxt;
			serial_clock_pin <= serial_clock_pin ^ tx_tick_w;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_meta_r <= 1'b1;
			rx_s_r <= 1'b1;
			rx_d_r <= 1'b1;
			rx_st_r <= FR_IDLE;
			rx_sh_r <= '0;
			rx_cnt_r <= '0;
			rx_pbad_r <= 1'b0;
		end else begin
			rx_meta_r <= serial_in_pin;
			rx_s_r <= rx_meta_r;
			rx_d_r <= rx_s_r;
			rx_st_r <= rx_st_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_pbad_r <= rx_pbad_nxt;
		end
	end
endmodule
`default_nettype wire

// [core/ucs_pkg.sv]
// Shared constants, register map and carrier types for the serial channel unit.
package ucs_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned NUM_CH = 2;
	localparam int unsigned DIV_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned CLK_MHZ = 200;
	// Receive-enable to start-trigger setup time, in operating-clock cycles.
	localparam int unsigned RX_EN_SETUP_CLK = 4;

	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFF_START = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STOP = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RUN = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_TX_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_TX_DATA = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_RX_STATUS = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_RX_DATA = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 8'h1c;
	localparam logic [ADDR_W-1:0] OFF_DIVISOR = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_ERR_CLEAR = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR = 8'h2c;
	localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h30;

	// Channel numbers.
	localparam int unsigned CH_TX = 0;
	localparam int unsigned CH_RX = 1;

	// Status register fields.
	localparam int unsigned ST_BUSY_BIT = 6;
	localparam int unsigned ST_BUF_BIT = 5;
	localparam int unsigned ST_FE_BIT = 2;
	localparam int unsigned ST_PE_BIT = 1;
	localparam int unsigned ST_OV_BIT = 0;

	// Control register fields.
	localparam int unsigned CTL_RXE_BIT = 0;
	localparam int unsigned CTL_PAR_LSB = 1;
	localparam int unsigned CTL_PAR_MSB = 2;

	// Interrupt status fields.
	localparam int unsigned IRQ_TX_END = 0;
	localparam int unsigned IRQ_RX_END = 1;
	localparam int unsigned IRQ_RX_ERR = 2;

	// Reset values and last data-bit index.
	localparam logic [DIV_W-1:0] DIV_RESET = 16'h00ff;
	localparam logic [2:0] CTL_RESET = 3'h0;
	localparam logic [2:0] LAST_BIT = 3'h7;

	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_ZERO = 2'h1,
		PAR_EVEN = 2'h2,
		PAR_ODD = 2'h3
	} ucs_par_e;

	typedef enum {
		FR_IDLE,
		FR_START,
		FR_DATA,
		FR_PAR,
		FR_STOP
	} ucs_frame_e;

	typedef struct packed {
		logic read;
		logic write;
		logic [ADDR_W-1:0] address;
		logic [DATA_W-1:0] writedata;
	} ucs_av_req_s;

	typedef struct packed {
		logic waitrequest;
		logic [DATA_W-1:0] readdata;
	} ucs_av_rsp_s;
endpackage

// [verification/uart_channel_start_stop_status_tb_top.sv]
// Self-checking bench for the serial channel unit.
`timescale 1ns/10ps
`default_nettype none
module uart_channel_start_stop_status_tb_top;
	import ucs_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	ucs_av_req_s req = '0;
	ucs_av_rsp_s rsp;
	logic sin;
	logic sout;
	logic sck;
	logic irq;
	logic [31:0] rd;
	logic [1:0] p;
	logic [15:0] lfsr = 16'h8fc5;
	int fail_count = 0;
	int check_count = 0;
	int run_m = 0;
	always #2.5 clk = ~clk;
	ucs_channel_unit u_ucs_channel_unit (.clk(clk), .rst(rst),
		.av_req(req), .av_rsp(rsp), .serial_in_pin(sin),
		.serial_out_pin(sout), .serial_clock_pin(sck), .irq(irq));
	ucs_remote_peer u_ucs_remote_peer (.clk(clk), .period(16'h0004),
		.line_in(sout), .line_out(sin));
	task automatic check(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		lfsr_next = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		req <= '{read: !w, write: w, address: a, writedata: d};
		do begin
			@(posedge clk);
			n++;
		end while (rsp.waitrequest !== 1'b0 && n < 50);
		rd = rsp.readdata;
		if (n >= 50) fail_count++;
		req <= '0;
	endtask
	task automatic rchk(input logic [7:0] a, input int e, input string n);
		bus(1'b0, a, 0);
		check(n, rd, e);
	endtask
	task automatic poll(input logic [7:0] a, input int b, input logic v);
		for (int n = 0; n < 60; n++) begin
			bus(1'b0, a, 0);
			if (rd[b] === v) return;
		end
		fail_count++;
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		summarize();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		rchk(OFF_TX_STATUS, 0, "tx status");
		rchk(OFF_START, 0, "start read");
		rchk(8'hfc, 0, "unmapped");
		bus(1'b1, OFF_DIVISOR, 3);
		bus(1'b1, OFF_CONTROL, 1);
		repeat (4) @(posedge clk);
		bus(1'b1, OFF_START, 0);
		bus(1'b1, OFF_STOP, 0);
		rchk(OFF_RUN, 0, "zero trig");
		for (int i = 0; i < 12; i++) begin
			lfsr = lfsr_next(lfsr);
			bus(1'b1, lfsr[2] ? OFF_STOP : OFF_START, int'(lfsr[1:0]));
			if (lfsr[2]) run_m = run_m & ~int'(lfsr[1:0]);
			else run_m = run_m | int'(lfsr[1:0]);
			rchk(OFF_RUN, run_m, "run");
		end
		$display("test triggers done");
		bus(1'b1, OFF_STOP, 1);
		bus(1'b1, OFF_TX_DATA, 8'ha5);
		rchk(OFF_TX_STATUS, 32'h20, "buf full");
		p = {sout, sck};
		repeat (30) @(posedge clk);
		check("pins", 32'({sout, sck}), 32'(p));
		bus(1'b1, OFF_IRQ_ENABLE, 0);
		bus(1'b1, OFF_START, 1);
		poll(OFF_TX_STATUS, ST_BUSY_BIT, 1'b0);
		check("buf empty", 32'(rd[5]), 0);
		@(negedge clk);
		check("irq masked", 32'(irq), 0);
		check("tx byte", 32'(u_ucs_remote_peer.got_q[0]), 32'h0a5);
		bus(1'b1, OFF_IRQ_ENABLE, 1);
		@(negedge clk);
		check("irq set", 32'(irq), 1);
		bus(1'b1, OFF_IRQ_CLEAR, 1);
		@(negedge clk);
		check("irq clear", 32'(irq), 0);
		$display("test buffer done");
		bus(1'b1, OFF_TX_DATA, 8'h3c);
		repeat (10) @(posedge clk);
		bus(1'b1, OFF_STOP, 1);
		@(negedge clk);
		p = {sout, sck};
		repeat (30) @(posedge clk);
		check("pins frozen", 32'({sout, sck}), 32'(p));
		bus(1'b1, OFF_START, 3);
		poll(OFF_TX_STATUS, ST_BUSY_BIT, 1'b0);
		$display("test stop done");
		u_ucs_remote_peer.send(8'h5a);
		poll(OFF_RX_STATUS, ST_BUF_BIT, 1'b1);
		rchk(OFF_RX_DATA, 32'h5a, "rx byte");
		bus(1'b1, OFF_STOP, 2);
		u_ucs_remote_peer.send(8'h77);
		bus(1'b0, OFF_RX_STATUS, 0);
		check("rx stopped", 32'(rd[5]), 0);
		bus(1'b1, OFF_CONTROL, 5);
		repeat (4) @(posedge clk);
		bus(1'b1, OFF_START, 2);
		u_ucs_remote_peer.send(8'h03);
		poll(OFF_RX_STATUS, ST_BUF_BIT, 1'b1);
		bus(1'b1, OFF_STOP, 2);
		repeat (20) @(posedge clk);
		rchk(OFF_RX_STATUS, 32'h22, "errors kept");
		rchk(OFF_CONTROL, 5, "control kept");
		bus(1'b1, OFF_ERR_CLEAR, 7);
		rchk(OFF_RX_STATUS, 32'h20, "errors cleared");
		$display("test receive done");
		summarize();
	end
endmodule
bind ucs_channel_unit ucs_channel_unit_properties
	u_ucs_channel_unit_properties (.clk(clk), .rst(rst),
	.av_req(av_req), .av_rsp(av_rsp), .serial_in_pin(serial_in_pin),
	.serial_out_pin(serial_out_pin), .serial_clock_pin(serial_clock_pin),
	.irq(irq));
`default_nettype wire

// [verification/ucs_channel_unit_properties.sv]
// Port-level properties of the serial channel unit.
`timescale 1ns/10ps
`default_nettype none
module ucs_channel_unit_properties (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Register bus.
	input wire ucs_pkg::ucs_av_req_s av_req,
	input wire ucs_pkg::ucs_av_rsp_s av_rsp,
	// Pins.
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic serial_clock_pin,
	input wire logic irq
);
	import ucs_pkg::*;
	logic [1:0] run_r;
	logic full_r;
	logic empty_r;
	wire logic wr_ok = av_req.write && !av_rsp.waitrequest;
	wire logic rd_ok = av_req.read && !av_rsp.waitrequest;
	wire logic [7:0] a = av_req.address;
	wire logic [1:0] wd = av_req.writedata[1:0];
	wire logic rd_st = rd_ok && a == OFF_TX_STATUS;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			run_r <= 2'h0;
			full_r <= 1'b0;
			empty_r <= 1'b1;
		end else if (wr_ok) begin
			if (a == OFF_START) run_r <= run_r | wd;
			if (a == OFF_STOP) run_r <= run_r & ~wd;
			if (a == OFF_START && wd[0]) full_r <= 1'b0;
			if (a == OFF_TX_DATA) full_r <= !run_r[0];
			if (a == OFF_TX_DATA) empty_r <= 1'b0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_run_status_match: assert property (
		rd_ok && a == OFF_RUN |-> av_rsp.readdata == {30'h0, run_r})
		else $error("run status differs from triggers");
	a_trigger_reads_zero: assert property (
		rd_ok && (a == OFF_START || a == OFF_STOP) |-> av_rsp.readdata == 0)
		else $error("trigger register holds state");
	a_buf_flag_full: assert property (
		rd_st && full_r |-> av_rsp.readdata[ST_BUF_BIT])
		else $error("buffer flag low with data held");
	a_buf_flag_empty: assert property (
		rd_st && empty_r |-> !av_rsp.readdata[ST_BUF_BIT])
		else $error("buffer flag high with no data");
	a_tx_err_kept: assert property (
		rd_st |-> av_rsp.readdata[2:0] == 3'h0)
		else $error("transmit error flags changed");
	a_stopped_pins_hold: assert property (
		!run_r[0] && !$past(run_r[0]) |->
		$stable(serial_out_pin) && $stable(serial_clock_pin))
		else $error("serial pins moved while stopped");
endmodule
`default_nettype wire

// [verification/ucs_remote_peer.sv]
// Remote serial device facing the unit's pins.
`timescale 1ns/10ps
`default_nettype none
module ucs_remote_peer (
	// Clock and bit period.
	input wire logic clk,
	input wire logic [15:0] period,
	// Serial lines.
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial line_out = 1'b1;
	always begin
		@(negedge line_in);
		repeat (period / 2 + period) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			sh[i] = line_in;
			repeat (period) @(posedge clk);
		end
		if (line_in) got_q.push_back(sh);
	end
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_out <= f[i];
			repeat (period) @(posedge clk);
		end
	endtask
endmodule
`default_nettype wire
